// [sim/error_status_flags_chk.sv]
// Assertion checker for the error status flag bank
`timescale 1ns/1ps
module error_status_flags_chk (
    input wire        I_MCLK,
    input wire        I_RST_N,
    input wire        I_NEG_INPUT_RANGE_FAULT,
    input wire        I_ACCESS_IGNORED,
    input wire        I_CLAMP_POS,
    input wire        I_CLAMP_NEG,
    input wire        I_CAL_RANGE_FAULT,
    input wire        I_MOD_SATURATION,
    input wire        I_REG_WR,
    input wire        I_REG_RD,
    input wire        O_REG_RVALID,
    input wire [7:0]  I_REG_ADDR,
    input wire [15:0] I_REG_WDATA,
    input wire [15:0] O_REG_RDATA,
    input wire [15:0] O_ERROR_FLAGS
);
    wire cv = I_CLAMP_POS | I_CLAMP_NEG | I_CAL_RANGE_FAULT | I_MOD_SATURATION;
    wire w6 = I_REG_WR && I_REG_ADDR == 8'h06;
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    a_rvalid_follows: assert property (I_REG_RD |=> O_REG_RVALID)
        else $error("no read valid");
    a_unmapped_zero: assert property (
        I_REG_RD && I_REG_ADDR[7:1] != 7'h03 |=> O_REG_RDATA == 16'h0000)
        else $error("unmapped read data");
    a_reserved_zero: assert property (
        ((O_ERROR_FLAGS | O_REG_RDATA) & 16'hF81F) == 16'h0000) else $error("reserved bit");
    a_clear_only_w1c: assert property (
        ($past(O_ERROR_FLAGS) & ~O_ERROR_FLAGS & ~($past(w6) ? $past(I_REG_WDATA) : 16'h0))
        == 16'h0000) else $error("flag fell without clear");
    a_conv_clears: assert property (w6 && I_REG_WDATA[7] && !cv |=> !O_ERROR_FLAGS[7])
        else $error("converter flag kept");
    a_conv_cause: assert property ($rose(O_ERROR_FLAGS[7]) |-> $past(cv))
        else $error("converter flag uncaused");
    a_neg_cause: assert property (
        $rose(O_ERROR_FLAGS[10]) |-> $past(I_NEG_INPUT_RANGE_FAULT, 3))
        else $error("input flag uncaused");
    a_ignore_cause: assert property (
        $rose(O_ERROR_FLAGS[6]) |-> $past(I_ACCESS_IGNORED) || $past(I_ACCESS_IGNORED, 2))
        else $error("ignore flag uncaused");
    cover property ($rose(O_ERROR_FLAGS[5]));
    cover property ($rose(O_ERROR_FLAGS[6]));
    cover property ($rose(O_ERROR_FLAGS[10]));
    cover property (w6 && I_REG_WDATA[7] && cv ##1 O_ERROR_FLAGS[7]);
endmodule
bind error_status_flags error_status_flags_chk chk (.*);

// [sim/error_status_flags_tb_top.sv]
// Self-checking testbench for the error status flag bank
`timescale 1ns/1ps
module error_status_flags_tb_top;
    logic        clk = 0, rst_n = 0, neg = 0, rr = 0, rm = 0, ign = 0, wr = 0, rd = 0;
    logic [3:0]  cv = 0;
    logic [7:0]  ad = 0;
    logic [15:0] wd = 0, rdata, flags;
    logic        rvalid, sclk, cs_n;
    int          error_cnt = 0, n_compared = 0;
    always #5 clk = ~clk;
    serial_host host (.o_sclk(sclk), .o_cs_n(cs_n));
    error_status_flags uut (.I_MCLK(clk), .I_RST_N(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
        .I_NEG_INPUT_RANGE_FAULT(neg), .I_REFERENCE_RANGE_FAULT(rr), .I_REFERENCE_MISSING(rm),
        .I_CLAMP_POS(cv[0]), .I_CLAMP_NEG(cv[1]), .I_CAL_RANGE_FAULT(cv[2]),
        .I_MOD_SATURATION(cv[3]), .I_ACCESS_IGNORED(ign), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_ADDR(ad), .I_REG_WDATA(wd), .O_REG_RDATA(rdata), .O_REG_RVALID(rvalid),
        .O_ERROR_FLAGS(flags));
    task automatic check(input string nm, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        ad = a;
        wd = d;
        wr = 1'h1;
        @(negedge clk);
        wr = 1'h0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk);
        ad = a;
        rd = 1'h1;
        @(negedge clk);
        rd = 1'h0;
        check("rvalid", 16'h0001, {15'h0, rvalid});
        check("rdata", e, rdata);
        if (a == 8'h06)
            check("flags", e, flags);
    endtask
    task automatic t_reset;
        rreg(8'h06, 16'h0000);
        rreg(8'h07, 16'h0040);
        wreg(8'h08, 16'hFFFF);
        rreg(8'h08, 16'h0000);
    endtask
    task automatic t_disabled;
        {neg, rr, rm, cv} = 7'h7F;
        repeat (6) @(negedge clk);
        {neg, rr, rm, cv} = 7'h00;
        rreg(8'h06, 16'h0000);
        ign = 1;
        host.frame(7);
        repeat (6) @(negedge clk);
        ign = 0;
        rreg(8'h06, 16'h0040);
    endtask
    task automatic t_sources;
        wreg(8'h07, 16'hFFFF);
        rreg(8'h07, 16'h07E0);
        for (int i = 0; i < 4; i++) begin
            wreg(8'h06, 16'h00C0);
            cv = 4'h1 << i;
            @(negedge clk);
            cv = 0;
            rreg(8'h06, 16'h0080);
        end
        cv = 4'h1;
        wreg(8'h06, 16'h0080);
        cv = 4'h0;
        rreg(8'h06, 16'h0080);
        {neg, rr, rm} = 3'h7;
        repeat (5) @(negedge clk);
        {neg, rr, rm} = 3'h0;
        wreg(8'h06, 16'h0080);
        repeat (4) @(negedge clk);
        rreg(8'h06, 16'h0700);
        wreg(8'h06, 16'h0100);
        rreg(8'h06, 16'h0600);
        wreg(8'h06, 16'h0200);
        rreg(8'h06, 16'h0400);
        wreg(8'h06, 16'h0400);
        rreg(8'h06, 16'h0000);
    endtask
    task automatic t_frames;
        int n[4] = '{7, 8, 16, 9};
        for (int i = 0; i < 4; i++) begin
            host.frame(n[i]);
            repeat (6) @(negedge clk);
            rreg(8'h06, n[i] % 8 ? 16'h0020 : 16'h0000);
            wreg(8'h06, 16'h0020);
        end
    endtask
    task automatic final_report;
        if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        final_report;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        t_reset;
        t_disabled;
        t_sources;
        t_frames;
        final_report;
    end
endmodule

// [sim/serial_host.sv]
// Serial host model driving chip select and serial clock frames
`timescale 1ns/1ps
module serial_host (
    output logic o_sclk,
    output logic o_cs_n
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
    end
    task automatic frame(input int n);
        o_cs_n = 1'b0;
        #40;
        repeat (n) begin
            o_sclk = 1'b1;
            #40 o_sclk = 1'b0;
            #40;
        end
        o_cs_n = 1'b1;
        #40;
    endtask
endmodule

// [src/error_status_flags.v]
// Sticky error status flags with enable register and frame clock checking
`timescale 1ns/1ps
`include "error_status_flags_defs.vh"

module error_status_flags (
    input  wire        I_MCLK,
    input  wire        I_RST_N,
    input  wire        I_SCLK,
    input  wire        I_CS_N,
    input  wire        I_NEG_INPUT_RANGE_FAULT,
    input  wire        I_REFERENCE_RANGE_FAULT,
    input  wire        I_REFERENCE_MISSING,
    input  wire        I_CLAMP_POS,
    input  wire        I_CLAMP_NEG,
    input  wire        I_CAL_RANGE_FAULT,
    input  wire        I_MOD_SATURATION,
    input  wire        I_ACCESS_IGNORED,
    input  wire        I_REG_WR,
    input  wire        I_REG_RD,
    input  wire [7:0]  I_REG_ADDR,
    input  wire [15:0] I_REG_WDATA,
    output wire [15:0] O_REG_RDATA,
    output wire        O_REG_RVALID,
    output wire [15:0] O_ERROR_FLAGS
);

    // ------------------------------------------------------------
    // Synchronisers for pins and analog comparators
    // ------------------------------------------------------------
    reg  [`SYNC_W-1:0] sync1_reg;
    reg  [`SYNC_W-1:0] sync2_reg;
    reg                sclk_d_reg;
    reg                cs_n_d_reg;
    wire               sclk_s;
    wire               cs_n_s;
    wire               neg_fault_s;
    wire               ref_fault_s;
    wire               ref_missing_s;

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            sync1_reg <= `SYNC_RST;
            sync2_reg <= `SYNC_RST;
        end else begin
            sync1_reg <= {I_CS_N, I_SCLK, I_NEG_INPUT_RANGE_FAULT,
                          I_REFERENCE_RANGE_FAULT, I_REFERENCE_MISSING};
            sync2_reg <= sync1_reg;
        end
    end

    assign cs_n_s        = sync2_reg[`SYNC_CS_N];
    assign sclk_s        = sync2_reg[`SYNC_SCLK];
    assign neg_fault_s   = sync2_reg[`SYNC_NEG_INPUT];
    assign ref_fault_s   = sync2_reg[`SYNC_REF_RANGE];
    assign ref_missing_s = sync2_reg[`SYNC_REF_MISSING];

    // ------------------------------------------------------------
    // Edge detection on synchronised pins
    // ------------------------------------------------------------
    wire                    frame_start;
    wire                    frame_end;
    wire                    sclk_rise;

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            sclk_d_reg <= `SCLK_IDLE;
            cs_n_d_reg <= `CS_N_IDLE;
        end else begin
            sclk_d_reg <= sclk_s;
            cs_n_d_reg <= cs_n_s;
        end
    end

    assign frame_start = cs_n_d_reg & ~cs_n_s;
    assign frame_end   = ~cs_n_d_reg & cs_n_s;
    assign sclk_rise   = ~sclk_d_reg & sclk_s & ~cs_n_s;

    // ------------------------------------------------------------
    // Frame clock counter
    // ------------------------------------------------------------
    reg  [`FRAME_CNT_W-1:0] frame_cnt_reg;
    reg  [`FRAME_CNT_W-1:0] frame_cnt_next;
    wire [`FRAME_CNT_W:0]   frame_cnt_sum;

    // Carry dropped on purpose, count runs modulo eight
    assign frame_cnt_sum = {1'h0, frame_cnt_reg} + {1'h0, `FRAME_CNT_ONE};

    always @* begin
        frame_cnt_next = frame_cnt_reg;
        if (frame_start) begin
            frame_cnt_next = `FRAME_CNT_ZERO;
        end else if (sclk_rise) begin
            frame_cnt_next = frame_cnt_sum[`FRAME_CNT_W-1:0];
        end
    end

    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            frame_cnt_reg <= `FRAME_CNT_ZERO;
        end else begin
            frame_cnt_reg <= frame_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Flag set sources
    // ------------------------------------------------------------
    reg  [15:0] set_vec;

    always @* begin
        set_vec = `ZERO_WORD;
        set_vec[`BIT_NEG_INPUT]   = neg_fault_s;
        set_vec[`BIT_REF_RANGE]   = ref_fault_s;
        set_vec[`BIT_REF_MISSING] = ref_missing_s;
        set_vec[`BIT_CONVERTER]   = I_CLAMP_POS | I_CLAMP_NEG |
                                    I_CAL_RANGE_FAULT | I_MOD_SATURATION;
        set_vec[`BIT_IGNORED]     = frame_start & I_ACCESS_IGNORED;
        set_vec[`BIT_CLOCK_COUNT] = frame_end & (frame_cnt_reg != `FRAME_CNT_ZERO);
    end

    // ------------------------------------------------------------
    // Status and enable registers
    // ------------------------------------------------------------
    reg  [15:0] status_reg;
    wire [15:0] status_next;
    reg  [15:0] enable_reg;
    reg  [15:0] enable_next;
    reg  [15:0] rdata_reg;
    reg  [15:0] rdata_next;
    reg         rvalid_reg;
    wire [15:0] flag_mask;
    wire        wr_status;
    wire        wr_enable;

    assign flag_mask = `FLAG_MASK;

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    assign wr_status = I_REG_WR & (I_REG_ADDR == `ADDR_ERROR_STATUS);
    assign wr_enable = I_REG_WR & (I_REG_ADDR == `ADDR_ERROR_ENABLE);

    always @* begin
        enable_next = enable_reg;
        if (wr_enable) begin
            enable_next = I_REG_WDATA & `FLAG_MASK;
        end
    end

    // ------------------------------------------------------------
    // Sticky flag bits
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `STATUS_W; gi = gi + 1) begin : g_flag
            wire set_bit;
            wire clear_bit;
            assign set_bit   = set_vec[gi] & enable_reg[gi] & flag_mask[gi];
            assign clear_bit = wr_status & I_REG_WDATA[gi];
            assign status_next[gi] = flag_mask[gi] & (set_bit | (status_reg[gi] & ~clear_bit));
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data path
    // ------------------------------------------------------------
    always @* begin
        rdata_next = rdata_reg;
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                `ADDR_ERROR_STATUS: begin
                    rdata_next = status_reg;
                end
                `ADDR_ERROR_ENABLE: begin
                    rdata_next = enable_reg;
                end
                default: begin
                    rdata_next = `ZERO_WORD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register update
    // ------------------------------------------------------------
    always @(posedge I_MCLK) begin
        if (!I_RST_N) begin
            status_reg <= `RST_ERROR_STATUS;
            enable_reg <= `RST_ERROR_ENABLE;
            rdata_reg  <= `ZERO_WORD;
            rvalid_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            enable_reg <= enable_next;
            rdata_reg  <= rdata_next;
            rvalid_reg <= I_REG_RD;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign O_REG_RDATA   = rdata_reg;
    assign O_REG_RVALID  = rvalid_reg;
    assign O_ERROR_FLAGS = status_reg;

endmodule

// [src/error_status_flags_defs.vh]
// Constants for the sticky error status flag bank
`ifndef ERROR_STATUS_FLAGS_DEFS_VH
`define ERROR_STATUS_FLAGS_DEFS_VH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define ADDR_ERROR_STATUS   8'h06
`define ADDR_ERROR_ENABLE   8'h07
`define RST_ERROR_STATUS    16'h0000
`define RST_ERROR_ENABLE    16'h0040
`define ZERO_WORD           16'h0000

// ----------------------------------------------------------------
// Flag bit positions
// ----------------------------------------------------------------
`define BIT_NEG_INPUT       10
`define BIT_REF_RANGE       9
`define BIT_REF_MISSING     8
`define BIT_CONVERTER       7
`define BIT_IGNORED         6
`define BIT_CLOCK_COUNT     5
`define FLAG_MASK           16'h07E0

// ----------------------------------------------------------------
// Frame clock counting
// ----------------------------------------------------------------
`define FRAME_CNT_W         3
`define FRAME_CNT_ZERO      3'h0
`define FRAME_CNT_ONE       3'h1

// ----------------------------------------------------------------
// Synchroniser layout, widths and idle levels
// ----------------------------------------------------------------
`define STATUS_W            16
`define SYNC_W              5
`define SYNC_RST            5'h1C
`define SYNC_CS_N           4
`define SYNC_SCLK           3
`define SYNC_NEG_INPUT      2
`define SYNC_REF_RANGE      1
`define SYNC_REF_MISSING    0
`define SCLK_IDLE           1'h0
`define CS_N_IDLE           1'h1

`endif
